// ==== hdl/tsw_pkg.sv ====
// Package of constants for the TDM switch host port
// Functional notes
// - In acknowledge style the device drives acknowledge low on completion.
// - In separate-strobe style completion is a low-to-high acknowledge edge.
// - The master selects with chip select low; the device ignores it high.
// - In separate-strobe style a falling direction/write line marks a write.
// - In acknowledge style an access needs data strobe and chip select low.
// - In separate-strobe style a falling strobe/read line marks a read.
// - The master gives a 14-bit address for the register or memory location.
// - Style select high or open gives acknowledge style, low separate strobe.
// - In reset all 32 serial outputs are off and all 16 controls are high.
// - Reset loads every register with its default and clears all counters.
// - Data uses a 16-bit two-way bus that the device drives only in reads.
package tsw_pkg;
  localparam int unsigned ADDR_W     = 14;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned NUM_STREAM = 32;
  localparam int unsigned NUM_HIZ    = 16;
  localparam int unsigned CLK_MHZ    = 50;
  // Internal access latency once a strobe is seen
  localparam int unsigned ACC_NS     = 60;
  localparam int unsigned ACC_CYC    = (ACC_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0]  ACC_CNT_W1 = 4'(ACC_CYC);
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  localparam logic [NUM_HIZ-1:0] HIZ_RST = 16'hffff;
  localparam logic [NUM_STREAM-1:0] OE_RST = 32'h0000_0000;
  typedef enum logic [2:0] {
    TSW_IDLE = 3'b000,
    TSW_WAIT = 3'b001,
    TSW_DONE = 3'b010,
    TSW_HOLD = 3'b011
  } tsw_state_t;
endpackage

// ==== hdl/tsw_host_port.sv ====
// Host microprocessor port of the TDM switch with reset behaviour
`timescale 1ns/10ps
`default_nettype none
module tsw_host_port (
  input  wire logic                      ref_clk,
  input  wire logic                      nrst,
  input  wire logic                      bus_style_select,
  input  wire logic                      cs_n,
  input  wire logic                      rw_wr_n,
  input  wire logic                      data_strobe_or_read_n,
  input  wire logic [tsw_pkg::ADDR_W-1:0] host_addr,
  input  wire logic [tsw_pkg::DATA_W-1:0] host_data_in,
  output var  logic [tsw_pkg::DATA_W-1:0] host_data_out,
  output var  logic                      host_data_oe,
  output var  logic                      xfer_ack_ready_n_out,
  output var  logic                      xfer_ack_ready_n_oe,
  output var  logic [tsw_pkg::ADDR_W-1:0] mem_addr,
  output var  logic [tsw_pkg::DATA_W-1:0] mem_wdata,
  output var  logic                      mem_we,
  output var  logic                      mem_re,
  input  wire logic [tsw_pkg::DATA_W-1:0] mem_rdata,
  output var  logic [tsw_pkg::NUM_STREAM-1:0] serial_out_oe,
  output var  logic [tsw_pkg::NUM_HIZ-1:0] ext_hiz_control,
  input  wire logic [tsw_pkg::NUM_HIZ-1:0] hiz_request
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic [tsw_pkg::ADDR_W-1:0] addr1_r;
  logic [tsw_pkg::ADDR_W-1:0] addr2_r;
  logic [tsw_pkg::DATA_W-1:0] din1_r;
  logic [tsw_pkg::DATA_W-1:0] din2_r;
  logic       cs_s;
  logic       rw_s;
  logic       ds_s;
  logic       style_s;
  logic       rw_prev_r;
  logic       ds_prev_r;
  logic       ack_style_r;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sync1_r <= 4'hf;
      sync2_r <= 4'hf;
      addr1_r <= '0;
      addr2_r <= '0;
      din1_r  <= '0;
      din2_r  <= '0;
    end else begin
      sync1_r <= {bus_style_select, cs_n, rw_wr_n, data_strobe_or_read_n};
      sync2_r <= sync1_r;
      addr1_r <= host_addr;
      addr2_r <= addr1_r;
      din1_r  <= host_data_in;
      din2_r  <= din1_r;
    end
  end

  assign style_s = sync2_r[3];
  assign cs_s    = sync2_r[2];
  assign rw_s    = sync2_r[1];
  assign ds_s    = sync2_r[0];

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rw_prev_r   <= 1'b1;
      ds_prev_r   <= 1'b1;
      ack_style_r <= 1'b1;
    end else begin
      rw_prev_r   <= rw_s;
      ds_prev_r   <= ds_s;
      ack_style_r <= style_s;
    end
  end

  // ****************************************
  // Access detection
  // ****************************************
  logic sel;
  logic start;
  logic start_wr;
  logic wr_fall;
  logic rd_fall;

  assign sel      = !cs_s;
  assign wr_fall  = rw_prev_r && !rw_s;
  assign rd_fall  = ds_prev_r && !ds_s;
  // Acknowledge style: strobe and select both low, direction from rw
  always_comb begin
    if (ack_style_r) begin
      start    = sel && !ds_s;
      start_wr = !rw_s;
    end else begin
      start    = sel && (wr_fall || rd_fall);
      start_wr = wr_fall;
    end
  end

  // Access still requested by the master
  function automatic logic still_active(input logic style,
                                        input logic s_n,
                                        input logic ds,
                                        input logic rw);
    still_active = !s_n && (style ? !ds : (!ds || !rw));
  endfunction

  // ****************************************
  // Transfer state machine
  // ****************************************
  tsw_pkg::tsw_state_t state_r;
  logic [3:0] cnt_r;
  logic       is_wr_r;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= tsw_pkg::TSW_IDLE;
      cnt_r   <= 4'h0;
      is_wr_r <= 1'b0;
    end else begin
      case (state_r)
        tsw_pkg::TSW_IDLE: begin
          if (start) begin
            state_r <= tsw_pkg::TSW_WAIT;
            cnt_r   <= tsw_pkg::ACC_CNT_W1;
            is_wr_r <= start_wr;
          end
        end
        tsw_pkg::TSW_WAIT: begin
          if (cs_s) begin
            state_r <= tsw_pkg::TSW_IDLE;
          end else if (cnt_r == 4'h1) begin
            state_r <= tsw_pkg::TSW_DONE;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        tsw_pkg::TSW_DONE: begin
          state_r <= tsw_pkg::TSW_HOLD;
        end
        tsw_pkg::TSW_HOLD: begin
          if (!still_active(ack_style_r, cs_s, ds_s, rw_s)) begin
            state_r <= tsw_pkg::TSW_IDLE;
          end
        end
        default: begin
          state_r <= tsw_pkg::TSW_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Internal memory side
  // ****************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mem_addr  <= '0;
      mem_wdata <= tsw_pkg::DATA_RST;
      mem_we    <= 1'b0;
      mem_re    <= 1'b0;
    end else begin
      mem_we <= 1'b0;
      mem_re <= 1'b0;
      if (state_r == tsw_pkg::TSW_IDLE && start) begin
        mem_addr <= addr2_r;
        mem_re   <= !start_wr;
      end
      // Write data is latched before the completion edge
      if (state_r == tsw_pkg::TSW_WAIT && cnt_r == 4'h1 && !cs_s) begin
        mem_wdata <= din2_r;
        mem_we    <= is_wr_r;
      end
    end
  end

  // ****************************************
  // Host bus drivers
  // ****************************************
  logic done_now;
  assign done_now = (state_r == tsw_pkg::TSW_DONE) ||
                    (state_r == tsw_pkg::TSW_HOLD);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      host_data_out <= tsw_pkg::DATA_RST;
      host_data_oe  <= 1'b0;
    end else begin
      if (state_r == tsw_pkg::TSW_DONE && !is_wr_r) begin
        host_data_out <= mem_rdata;
      end
      // Drive only in a selected read
      host_data_oe <= sel && !is_wr_r
                      && (state_r != tsw_pkg::TSW_IDLE)
                      && still_active(ack_style_r, cs_s, ds_s, rw_s);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      xfer_ack_ready_n_out <= 1'b1;
      xfer_ack_ready_n_oe  <= 1'b0;
    end else begin
      xfer_ack_ready_n_oe <= sel;
      if (ack_style_r) begin
        xfer_ack_ready_n_out <= !(sel && done_now);
      end else begin
        // Low until done, so the idle pull-down level shows no false edge
        xfer_ack_ready_n_out <= sel && done_now;
      end
    end
  end

  // ****************************************
  // Serial output and high-impedance control
  // ****************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      serial_out_oe   <= tsw_pkg::OE_RST;
      ext_hiz_control <= tsw_pkg::HIZ_RST;
    end else begin
      serial_out_oe   <= {tsw_pkg::NUM_STREAM{1'b1}};
      ext_hiz_control <= hiz_request;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_read_done;
    state_r == tsw_pkg::TSW_DONE && !is_wr_r;
  endsequence

  a_ack_low_done: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    (ack_style_r && sel && state_r == tsw_pkg::TSW_DONE) |=>
      !xfer_ack_ready_n_out)
    else $error("ack not low on completion");

  a_ready_rise: assert property (@(posedge ref_clk) disable iff (!nrst)
    (!ack_style_r && sel && state_r == tsw_pkg::TSW_WAIT) ##1
      (sel && state_r == tsw_pkg::TSW_DONE) |=>
      $rose(xfer_ack_ready_n_out))
    else $error("ready did not rise on completion");

  a_cs_ignore: assert property (@(posedge ref_clk) disable iff (!nrst)
    (cs_s && state_r == tsw_pkg::TSW_IDLE) |=> state_r == tsw_pkg::TSW_IDLE)
    else $error("access started without chip select");

  a_wr_fall_start: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    (!ack_style_r && state_r == tsw_pkg::TSW_IDLE && sel && wr_fall) |=>
      (state_r == tsw_pkg::TSW_WAIT && is_wr_r))
    else $error("write edge not taken");

  a_ds_gate: assert property (@(posedge ref_clk) disable iff (!nrst)
    (ack_style_r && state_r == tsw_pkg::TSW_IDLE && ds_s) |=>
      state_r == tsw_pkg::TSW_IDLE)
    else $error("access without data strobe");

  a_rd_fall_start: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    (!ack_style_r && state_r == tsw_pkg::TSW_IDLE && sel && rd_fall
      && !wr_fall) |=> (state_r == tsw_pkg::TSW_WAIT && !is_wr_r))
    else $error("read edge not taken");

  a_ack_float: assert property (@(posedge ref_clk) disable iff (!nrst)
    cs_s |=> !xfer_ack_ready_n_oe)
    else $error("ack driven while deselected");

  a_bus_rd_only: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    host_data_oe |-> $past(!is_wr_r))
    else $error("data bus driven on write");

  a_read_data: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_read_done |=> host_data_out == $past(mem_rdata))
    else $error("read data not presented");

  a_hiz_reset: assert property (@(posedge ref_clk)
    $rose(nrst) |-> (ext_hiz_control == tsw_pkg::HIZ_RST
      && serial_out_oe == tsw_pkg::OE_RST))
    else $error("outputs not safe at reset release");

  a_ready_low_busy: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    (!ack_style_r && sel && state_r == tsw_pkg::TSW_WAIT) |=>
      !xfer_ack_ready_n_out)
    else $error("ready high while busy");

  a_wr_capture: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    (state_r == tsw_pkg::TSW_WAIT && cnt_r == 4'h1 && !cs_s && is_wr_r)
      |=> (mem_we && mem_wdata == $past(din2_r)))
    else $error("write data not captured");

  a_dir_latch: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    (ack_style_r && state_r == tsw_pkg::TSW_IDLE && start) |=>
      (is_wr_r == !$past(rw_s)))
    else $error("direction not taken from rw");

endmodule
`default_nettype wire

// ==== sim/tsw_master_model.sv ====
// Host bus master model for the TDM switch host port
`timescale 1ns/10ps
`default_nettype none
module tsw_master_model (
  input  wire logic        ref_clk,
  input  wire logic        style,
  output var  logic        cs_n,
  output var  logic        rw_wr_n,
  output var  logic        ds_n,
  output var  logic [13:0] addr,
  output var  logic [15:0] bus,
  input  wire logic [15:0] dut_d,
  input  wire logic        dut_oe,
  input  wire logic        ack_out,
  input  wire logic        ack_oe
);
  logic [15:0] wd;
  logic        wr_en;
  logic        ack_pin;
  // Undriven acknowledge rests at its pull-up or pull-down
  always_comb ack_pin = ack_oe ? ack_out : style;
  initial begin
    cs_n = 1'b1;
    rw_wr_n = 1'b1;
    ds_n = 1'b1;
    addr = 14'h0000;
    wd = 16'h0000;
    wr_en = 1'b0;
  end
  // Released bus shows inverted data, never a stale copy
  always_comb bus = dut_oe ? dut_d : (wr_en ? wd : ~wd);
  task automatic access(input logic wr, input logic [13:0] a,
                        input logic [15:0] d, output logic [15:0] rd,
                        output logic ok);
    int   n;
    logic seen;
    ok = 1'b0;
    seen = 1'b0;
    @(posedge ref_clk);
    #2;
    cs_n = 1'b0;
    addr = a;
    wd = d;
    wr_en = wr;
    if (style) rw_wr_n = ~wr;
    @(posedge ref_clk);
    #2;
    if (style) ds_n = 1'b0;
    else if (wr) rw_wr_n = 1'b0;
    else ds_n = 1'b0;
    for (n = 0; n < 40 && !ok; n++) begin
      @(posedge ref_clk);
      if (style) ok = (ack_pin === 1'b0);
      else begin
        ok = seen && (ack_pin === 1'b1);
        if (ack_pin === 1'b0) seen = 1'b1;
      end
    end
    rd = bus;
    #2;
    cs_n = 1'b1;
    ds_n = 1'b1;
    rw_wr_n = 1'b1;
    wr_en = 1'b0;
    repeat (6) @(posedge ref_clk);
  endtask
  // Strobes without chip select must be ignored
  task automatic stray();
    @(posedge ref_clk);
    #2;
    ds_n = 1'b0;
    rw_wr_n = 1'b0;
    repeat (12) @(posedge ref_clk);
    #2;
    ds_n = 1'b1;
    rw_wr_n = 1'b1;
    repeat (4) @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
// Self-checking testbench of the TDM switch host port
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        ref_clk, nrst, style, cs_n, rw_wr_n, ds_n, data_oe;
  logic        ack_out, ack_oe, mem_we, mem_re;
  logic [13:0] addr, mem_addr, we_a, a;
  logic [15:0] bus, dout, mem_wdata, mem_rdata, hiz_req, hiz, we_d, d;
  logic [31:0] soe;
  int          bad_count, tests_run, seed, we_n, re_n, s, k;
  tsw_host_port uut (.ref_clk(ref_clk), .nrst(nrst),
    .bus_style_select(style), .cs_n(cs_n), .rw_wr_n(rw_wr_n),
    .data_strobe_or_read_n(ds_n), .host_addr(addr), .host_data_in(bus),
    .host_data_out(dout), .host_data_oe(data_oe),
    .xfer_ack_ready_n_out(ack_out), .xfer_ack_ready_n_oe(ack_oe),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we),
    .mem_re(mem_re), .mem_rdata(mem_rdata), .serial_out_oe(soe),
    .ext_hiz_control(hiz), .hiz_request(hiz_req));
  tsw_master_model m (.ref_clk(ref_clk), .style(style), .cs_n(cs_n),
    .rw_wr_n(rw_wr_n), .ds_n(ds_n), .addr(addr), .bus(bus), .dut_d(dout),
    .dut_oe(data_oe), .ack_out(ack_out), .ack_oe(ack_oe));
  function automatic logic [15:0] exp_rd(input logic [13:0] x);
    return {2'h0, x} ^ 16'hc3a5;
  endfunction
  assign mem_rdata = exp_rd(mem_addr);
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (mem_we === 1'b1) begin
      we_n++;
      we_a = mem_addr;
      we_d = mem_wdata;
    end
    if (mem_re === 1'b1) re_n++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    if (bad_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic xfer(input logic wr, input logic [13:0] xa,
                      input logic [15:0] xd);
    logic [15:0] rd;
    logic        ok;
    int          w0, r0;
    w0 = we_n;
    r0 = re_n;
    m.access(wr, xa, xd, rd, ok);
    chk({31'h0, ok}, 32'h1);
    if (!ok) end_sim();
    if (wr) begin
      chk(32'(we_n - w0), 32'h1);
      chk({18'h0, we_a}, {18'h0, xa});
      chk({16'h0, we_d}, {16'h0, xd});
    end else begin
      chk(32'(re_n - r0), 32'h1);
      chk(32'(we_n - w0), 32'h0);
      chk({16'h0, rd}, {16'h0, exp_rd(xa)});
    end
  endtask
  initial begin
    seed = 67501;
    bad_count = 0;
    tests_run = 0;
    we_n = 0;
    re_n = 0;
    nrst = 1'b0;
    style = 1'b1;
    hiz_req = 16'h1234;
    repeat (4) @(posedge ref_clk);
    #2;
    chk(soe, 32'h0000_0000);
    chk({16'h0, hiz}, 32'h0000_ffff);
    chk({30'h0, data_oe, ack_oe}, 32'h0);
    chk({16'h0, dout}, 32'h0);
    repeat (4) @(posedge ref_clk);
    #2;
    nrst = 1'b1;
    repeat (3) @(posedge ref_clk);
    #2;
    chk(soe, 32'hffff_ffff);
    for (k = 0; k < 4; k++) begin
      hiz_req = 16'($random(seed));
      repeat (2) @(posedge ref_clk);
      #2;
      chk({16'h0, hiz}, {16'h0, hiz_req});
    end
    repeat (30000) @(posedge ref_clk);
    for (s = 1; s >= 0; s--) begin
      #2;
      style = s[0];
      repeat (4) @(posedge ref_clk);
      xfer(1'b1, 14'h3fff, 16'hffff);
      xfer(1'b0, 14'h0000, 16'h0000);
      for (k = 0; k < 8; k++) begin
        a = 14'($random(seed));
        d = 16'($random(seed));
        xfer(k[0] ^ s[0], a, d);
      end
      k = we_n + re_n;
      m.stray();
      chk(32'(we_n + re_n - k), 32'h0);
      chk({31'h0, ack_oe}, 32'h0);
    end
    #2;
    nrst = 1'b0;
    repeat (60) @(posedge ref_clk);
    #2;
    chk(soe, 32'h0000_0000);
    chk({16'h0, hiz}, 32'h0000_ffff);
    chk({16'h0, dout}, 32'h0);
    nrst = 1'b1;
    repeat (30000) @(posedge ref_clk);
    xfer(1'b0, 14'h2a5c, 16'h0000);
    end_sim();
  end
endmodule
`default_nettype wire
